/* hw/ehc_regs.sv */
`timescale 1ns/1ps
`include "ehc_cfg.svh"

module ehc_regs (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               host_sel_n,
    input  wire logic               host_rd_n,
    input  wire logic               host_wr_n,
    input  wire logic [15:0]        host_addr,
    input  wire logic [31:0]        host_wdata,
    output logic [31:0]             host_rdata,
    input  wire logic               phy_irq_req,
    input  wire logic               rx_pkt_stored,
    input  wire logic               tx_pkt_done,
    input  wire logic               wdt_expired,
    input  wire logic               rxbuf_full,
    input  wire logic               wake_req,
    input  wire logic [1:0]         tx_active_desc,
    input  wire logic               tx_data_waiting,
    output ehc_pkg::ehc_ctrl_t      ctrl,
    output ehc_pkg::ehc_txcmd_t     txcmd,
    output ehc_pkg::ehc_phy_t       phy,
    output logic [3:0]              desc_in_use,
    output logic                    irq_out,
    output logic                    wake_out
);
    import ehc_pkg::*;

    localparam logic [15:0] RST_CMD   = `EHC_RST_CMD;
    localparam logic [15:0] RST_TXCFG = `EHC_RST_TXCFG;
    localparam logic [15:0] RST_ZERO  = `EHC_RST_ZERO;
    localparam logic [15:0] EVT_BITS  = `EHC_EVT_BITS;

    ehc_ctrl_t   ctrl_ff;
    ehc_txcmd_t  txcmd_ff;
    ehc_phy_t    phy_ff;
    logic [15:0] mask_ff;
    logic [15:0] stat_ff;
    logic [15:0] nxt_stat;
    logic [3:0]  use_ff;
    logic [3:0]  nxt_use;
    logic        rd_prev_ff;
    logic        wr_prev_ff;
    logic [31:0] rdata_ff;
    logic        irq_ff;
    logic        wake_ff;
    logic        wr_take;
    logic        rd_take;
    ehc_reg_t    sel;
    logic [15:0] wd;
    logic [15:0] events;
    logic [15:0] rd_word;

    function automatic ehc_reg_t reg_decode(input logic [15:0] a);
        unique case (a)
            `EHC_OFF_CMD:   reg_decode = EHC_R_CMD;
            `EHC_OFF_MASK:  reg_decode = EHC_R_MASK;
            `EHC_OFF_STAT:  reg_decode = EHC_R_STAT;
            `EHC_OFF_TXCFG: reg_decode = EHC_R_TXCFG;
            `EHC_OFF_TXCMD: reg_decode = EHC_R_TXCMD;
            `EHC_OFF_TRANSMIT_BUFFER_STATE:  reg_decode = EHC_R_TRANSMIT_BUFFER_STATE;
            `EHC_OFF_PHY:   reg_decode = EHC_R_PHY;
            default:        reg_decode = EHC_R_NONE;
        endcase
    endfunction

    // Command and TX config words share one control struct
    function automatic ehc_ctrl_t ctrl_unpack(input logic [15:0] c, input logic [15:0] t);
        ehc_ctrl_t r;
        r.rx_tag_skip     = c[`EHC_B_RX_TAG];
        r.tx_tag_skip     = c[`EHC_B_TX_TAG];
        r.receive_allow   = c[`EHC_B_RX_ALLOW];
        r.transmit_allow  = c[`EHC_B_TX_ALLOW];
        r.irq_polarity    = c[`EHC_B_IRQ_POL];
        r.wake_polarity   = c[`EHC_B_WAKE_POL];
        r.fcs_auto_append = t[`EHC_B_FCS];
        r.tx_csum_insert  = t[`EHC_B_CSUM];
        return r;
    endfunction

    function automatic ehc_phy_t phy_unpack(input logic [15:0] p);
        ehc_phy_t r;
        r.speed_led_select    = p[`EHC_B_SPD_LED];
        r.link_led_select     = p[`EHC_B_LNK_LED];
        r.duplex_led_select   = p[`EHC_B_DUP_LED];
        r.phy_power_off       = p[`EHC_B_PWR_OFF];
        r.internal_phy_select = p[`EHC_B_INT_PHY];
        r.phy_link_mode       = p[`EHC_B_MODE +: 3];
        return r;
    endfunction

    // One access per strobe falling edge, so a held strobe cannot repeat a clear
    assign sel     = reg_decode(host_addr);
    assign wd      = host_wdata[15:0];
    assign wr_take = !host_sel_n && !host_wr_n && wr_prev_ff;
    assign rd_take = !host_sel_n && !host_rd_n && rd_prev_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_prev_ff <= 1'b1;
            rd_prev_ff <= 1'b1;
        end else begin
            wr_prev_ff <= host_sel_n || host_wr_n;
            rd_prev_ff <= host_sel_n || host_rd_n;
        end
    end

    // control bits steer the MAC and pin polarity
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff <= ctrl_unpack(RST_CMD, RST_TXCFG);
        end else if (wr_take && sel == EHC_R_CMD) begin
            ctrl_ff <= ctrl_unpack(wd, {9'h000, ctrl_ff.fcs_auto_append, 1'b0,
                                   ctrl_ff.tx_csum_insert, 4'h0});
        end else if (wr_take && sel == EHC_R_TXCFG) begin
            ctrl_ff.fcs_auto_append <= wd[`EHC_B_FCS];
            ctrl_ff.tx_csum_insert  <= wd[`EHC_B_CSUM];
        end
    end

    // write-session fields are stored for the buffer logic
    always_ff @(posedge clk) begin
        if (rst) begin
            txcmd_ff <= '0;
        end else if (wr_take && sel == EHC_R_TXCMD) begin
            txcmd_ff.host_write_flag   <= wd[`EHC_B_HWF];
            txcmd_ff.write_desc_select <= wd[`EHC_B_DSEL +: 2];
            txcmd_ff.write_byte_count  <= wd[`EHC_B_BCNT +: 12];
        end
    end

    // pin muxing and PHY selection; reserved mode 011 is kept as written
    always_ff @(posedge clk) begin
        if (rst) begin
            phy_ff <= phy_unpack(RST_ZERO);
        end else if (wr_take && sel == EHC_R_PHY) begin
            phy_ff <= phy_unpack(wd);
        end
    end

    // only implemented mask bits are stored
    always_ff @(posedge clk) begin
        if (rst) begin
            mask_ff <= RST_ZERO;
        end else if (wr_take && sel == EHC_R_MASK) begin
            mask_ff <= wd & EVT_BITS;
        end
    end

    // event pulses land on their status bits
    always_comb begin
        events = RST_ZERO;
        events[5] = phy_irq_req;
        events[4] = rx_pkt_stored;
        events[3] = tx_pkt_done;
        events[1] = wdt_expired;
        events[0] = rxbuf_full;
    end

    // write-one clear; an event in the same cycle wins
    always_comb begin
        nxt_stat = stat_ff;
        if (wr_take && sel == EHC_R_STAT) begin
            nxt_stat = stat_ff & ~(wd & EVT_BITS);
        end
        nxt_stat = nxt_stat | events;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stat_ff <= RST_ZERO;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    // host write stores in-use bits; completion clears the finished one
    always_comb begin
        nxt_use = use_ff;
        if (tx_pkt_done) begin
            nxt_use[tx_active_desc] = 1'b0;
        end
        if (wr_take && sel == EHC_R_TRANSMIT_BUFFER_STATE) begin
            nxt_use = wd[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            use_ff <= 4'h0;
        end else begin
            use_ff <= nxt_use;
        end
    end

    // level follows masked status, polarity applied last
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ff <= 1'b1;
        end else begin
            irq_ff <= (|(nxt_stat & mask_ff)) ? ctrl_ff.irq_polarity
                                               : !ctrl_ff.irq_polarity;
        end
    end

    // wake request driven at the chosen polarity
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= wake_req ? ctrl_ff.wake_polarity : !ctrl_ff.wake_polarity;
        end
    end

    // read-back assembly; unmapped offsets read zero
    always_comb begin
        rd_word = RST_ZERO;
        unique case (sel)
            EHC_R_CMD: begin
                rd_word[`EHC_B_RX_TAG]   = ctrl_ff.rx_tag_skip;
                rd_word[`EHC_B_TX_TAG]   = ctrl_ff.tx_tag_skip;
                rd_word[`EHC_B_RX_ALLOW] = ctrl_ff.receive_allow;
                rd_word[`EHC_B_TX_ALLOW] = ctrl_ff.transmit_allow;
                rd_word[`EHC_B_IRQ_POL]  = ctrl_ff.irq_polarity;
                rd_word[`EHC_B_WAKE_POL] = ctrl_ff.wake_polarity;
            end
            EHC_R_MASK:  rd_word = mask_ff;
            EHC_R_STAT:  rd_word = stat_ff;
            EHC_R_TXCFG: begin
                rd_word[`EHC_B_FCS]  = ctrl_ff.fcs_auto_append;
                rd_word[`EHC_B_CSUM] = ctrl_ff.tx_csum_insert;
                rd_word[1:0]         = tx_active_desc;
            end
            EHC_R_TXCMD: begin
                rd_word[`EHC_B_HWF]        = txcmd_ff.host_write_flag;
                rd_word[`EHC_B_DSEL +: 2]  = txcmd_ff.write_desc_select;
                rd_word[`EHC_B_BCNT +: 12] = txcmd_ff.write_byte_count;
            end
            EHC_R_TRANSMIT_BUFFER_STATE: begin
                rd_word[`EHC_B_PEND]      = tx_data_waiting;
                rd_word[`EHC_B_SEND +: 2] = tx_active_desc;
                rd_word[3:0]              = use_ff;
            end
            EHC_R_PHY: begin
                rd_word[`EHC_B_SPD_LED]  = phy_ff.speed_led_select;
                rd_word[`EHC_B_LNK_LED]  = phy_ff.link_led_select;
                rd_word[`EHC_B_DUP_LED]  = phy_ff.duplex_led_select;
                rd_word[`EHC_B_PWR_OFF]  = phy_ff.phy_power_off;
                rd_word[`EHC_B_INT_PHY]  = phy_ff.internal_phy_select;
                rd_word[`EHC_B_MODE +: 3] = phy_ff.phy_link_mode;
            end
            EHC_R_NONE:  rd_word = RST_ZERO;
        endcase
    end

    // Read data is held until the next read strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_take) begin
            rdata_ff <= {16'h0000, rd_word};
        end
    end

    assign host_rdata  = rdata_ff;
    assign ctrl        = ctrl_ff;
    assign txcmd       = txcmd_ff;
    assign phy         = phy_ff;
    assign desc_in_use = use_ff;
    assign irq_out     = irq_ff;
    assign wake_out    = wake_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_clear_write;
        wr_take && sel == EHC_R_STAT;
    endsequence

    chk_event_sets_flag: assert property (
        phy_irq_req |=> stat_ff[5]) else $error("phy event lost");
    chk_rx_done_flag: assert property (
        rx_pkt_stored |=> stat_ff[4]) else $error("rx event lost");
    chk_tx_done_flag: assert property (
        tx_pkt_done |=> stat_ff[3] && !use_ff[$past(tx_active_desc)] ||
        $past(wr_take && sel == EHC_R_TRANSMIT_BUFFER_STATE)) else $error("tx done not seen");
    chk_wdt_flag: assert property (
        wdt_expired |=> stat_ff[1]) else $error("wdt event lost");
    chk_full_flag: assert property (
        rxbuf_full |=> stat_ff[0]) else $error("full event lost");
    chk_w1c_clears: assert property (
        s_clear_write ##0 (wd[4] && !rx_pkt_stored) |=> !stat_ff[4])
        else $error("write one did not clear");
    chk_w0_keeps: assert property (
        s_clear_write ##0 (!wd[3] && stat_ff[3]) |=> stat_ff[3])
        else $error("write zero cleared flag");
    chk_irq_level: assert property (
        |(stat_ff & mask_ff) |=> irq_out == $past(ctrl_ff.irq_polarity) ||
        $past(wr_take && sel == EHC_R_STAT)) else $error("irq not raised");
    chk_irq_release: assert property (
        !(|(nxt_stat & mask_ff)) |=> irq_out != $past(ctrl_ff.irq_polarity))
        else $error("irq stuck active");
    chk_wake_polarity: assert property (
        wake_req ##1 1'b1 |-> wake_out == $past(ctrl_ff.wake_polarity))
        else $error("wake polarity wrong");
    chk_status_zero_bits: assert property (
        (stat_ff & ~EVT_BITS) == 16'h0000) else $error("reserved status set");

endmodule

/* include/ehc_cfg.svh */
`ifndef EHC_CFG_SVH
`define EHC_CFG_SVH
// Notes on behaviour
// - Tag-skip bits 15/14 make checksums skip four tag bytes per direction.
// - Bit 9 (reset 1) allows receive; bit 8 (reset 0) allows transmit.
// - Interrupt output active high when bit 6 is 1, else active low; reset 0.
// - Wake output active high when bit 0 is 1, else active low; reset 1.
// - Mask bits 5,4,3,1,0 gate same-position status bits onto the interrupt.
// - Status bit clears on writing 1; writing 0 leaves it.
// - Status bit 5 sets on a PHY interrupt request.
// - Status bit 4 sets when received packets are stored.
// - Status bit 3 sets when a transmission finishes.
// - Status bit 1 sets when the watchdog expires.
// - Status bit 0 sets when the receive buffer fills; receive then stalls.
// - Bit 6 (reset 1) appends computed FCS to every sent packet.
// - Bit 4 inserts computed IP/TCP/UDP checksum on transmit.
// - Config bits 1:0 read back the descriptor now being sent; reset 00.
// - Pending bit 8 reads 1 while transmit data waits, else 0.
// - Bits 5:4 encode the descriptor being transmitted, 0 to 3.
// - Host sets in-use bits 3:0; device clears one when its send ends.
// - Bits 12, 11, 10 steer LED pins instead of GPIO or PROM pins.
// - Bit 9 powers down internal PHY; bit 8 picks internal over external.
// - Bits 6:4 pick PHY link mode; 011 is reserved.

`define EHC_OFF_CMD     16'hfc00
`define EHC_OFF_MASK    16'hfc04
`define EHC_OFF_STAT    16'hfc08
`define EHC_OFF_TXCFG   16'hfc10
`define EHC_OFF_TXCMD   16'hfc14
`define EHC_OFF_TRANSMIT_BUFFER_STATE    16'hfc18
`define EHC_OFF_PHY     16'hfc1c

`define EHC_RST_CMD     16'h0201
`define EHC_RST_TXCFG   16'h0040
`define EHC_RST_ZERO    16'h0000
`define EHC_EVT_BITS    16'h003b

`define EHC_B_RX_TAG    15
`define EHC_B_TX_TAG    14
`define EHC_B_RX_ALLOW  9
`define EHC_B_TX_ALLOW  8
`define EHC_B_IRQ_POL   6
`define EHC_B_WAKE_POL  0
`define EHC_B_FCS       6
`define EHC_B_CSUM      4
`define EHC_B_HWF       15
`define EHC_B_DSEL      13
`define EHC_B_BCNT      0
`define EHC_B_PEND      8
`define EHC_B_SEND      4
`define EHC_B_SPD_LED   12
`define EHC_B_LNK_LED   11
`define EHC_B_DUP_LED   10
`define EHC_B_PWR_OFF   9
`define EHC_B_INT_PHY   8
`define EHC_B_MODE      4
`endif

/* include/ehc_pkg.sv */
package ehc_pkg;
    typedef struct packed {
        logic rx_tag_skip;
        logic tx_tag_skip;
        logic receive_allow;
        logic transmit_allow;
        logic irq_polarity;
        logic wake_polarity;
        logic fcs_auto_append;
        logic tx_csum_insert;
    } ehc_ctrl_t;

    typedef struct packed {
        logic        host_write_flag;
        logic [1:0]  write_desc_select;
        logic [11:0] write_byte_count;
    } ehc_txcmd_t;

    typedef struct packed {
        logic       speed_led_select;
        logic       link_led_select;
        logic       duplex_led_select;
        logic       phy_power_off;
        logic       internal_phy_select;
        logic [2:0] phy_link_mode;
    } ehc_phy_t;

    typedef enum logic [2:0] {
        EHC_R_NONE, EHC_R_CMD, EHC_R_MASK, EHC_R_STAT,
        EHC_R_TXCFG, EHC_R_TXCMD, EHC_R_TRANSMIT_BUFFER_STATE, EHC_R_PHY
    } ehc_reg_t;
endpackage

/* tb/ehc_host_model.sv */
`timescale 1ns/1ps
`include "ehc_cfg.svh"

module ehc_host_model (
    input  wire logic        clk,
    output logic             host_sel_n,
    output logic             host_rd_n,
    output logic             host_wr_n,
    output logic [15:0]      host_addr,
    output logic [31:0]      host_wdata,
    output logic             rd_valid
);
    initial begin
        host_sel_n = 1'b1;
        host_rd_n  = 1'b1;
        host_wr_n  = 1'b1;
        host_addr  = 16'h0;
        host_wdata = 32'h0;
        rd_valid   = 1'b0;
    end

    // Released lines show the inverse so a stale value never passes as live
    task automatic access(input logic [15:0] a, input logic [31:0] d, input logic rd);
        @(negedge clk);
        host_addr  = a;
        host_wdata = d;
        host_sel_n = 1'b0;
        host_rd_n  = ~rd;
        host_wr_n  = rd;
        @(negedge clk);
        host_sel_n = 1'b1;
        host_rd_n  = 1'b1;
        host_wr_n  = 1'b1;
        host_addr  = ~a;
        host_wdata = ~d;
        rd_valid   = rd;
        @(negedge clk);
        rd_valid   = 1'b0;
    endtask

    task automatic load_packet(input logic [1:0] desc, input logic [11:0] cnt,
                               input logic [3:0] occ);
        access(`EHC_OFF_TXCMD, {16'h0, 1'b1, desc, 1'b0, cnt}, 1'b0);
        access(`EHC_OFF_TXCMD, {16'h0, 1'b0, desc, 1'b0, cnt}, 1'b0);
        access(`EHC_OFF_TRANSMIT_BUFFER_STATE, {28'h0, occ | (4'h1 << desc)}, 1'b0);
    endtask
endmodule

/* tb/ethernet_host_control_regs_tb.sv */
`timescale 1ns/1ps
`include "ehc_cfg.svh"

module ethernet_host_control_regs_tb;
    import ehc_pkg::*;
    typedef struct {
        string       name;
        logic [36:0] exp;
    } ehc_note_t;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        host_sel_n;
    logic        host_rd_n;
    logic        host_wr_n;
    logic [15:0] host_addr;
    logic [31:0] host_wdata;
    logic [31:0] host_rdata;
    logic        rd_valid;
    logic        probe = 1'b0;
    logic [5:0]  ev = 6'h0;
    logic        wake_req = 1'b0;
    logic [1:0]  tx_active_desc = 2'h0;
    logic        tx_data_waiting = 1'b0;
    ehc_ctrl_t   ctrl;
    ehc_txcmd_t  txcmd;
    ehc_phy_t    phy;
    logic [3:0]  desc_in_use;
    logic        irq_out;
    logic        wake_out;
    logic [15:0] cmd_m = 16'h0201;
    logic [15:0] mask_m = 16'h0;
    logic [15:0] stat_m = 16'h0;
    logic [15:0] txcfg_m = 16'h0040;
    logic [15:0] txcmd_m = 16'h0;
    logic [15:0] phy_m = 16'h0;
    logic [3:0]  occ_m = 4'h0;
    logic [1:0]  pkt_desc;
    logic [11:0] pkt_cnt;
    logic [36:0] obs;
    ehc_note_t   n;
    ehc_note_t   note_q[$];
    int          fails = 0;
    int          n_tests = 0;
    logic [15:0] regs_a[8] = '{16'hfc00, 16'hfc04, 16'hfc08, 16'hfc0c,
                               16'hfc10, 16'hfc14, 16'hfc18, 16'hfc1c};
    int          evt_b[5] = '{5, 4, 3, 1, 0};
    // About 90 bus accesses of three cycles each, with ample margin
    localparam int WATCH_NS = 8000 * 20;

    always #10 clk = ~clk;

    ehc_host_model u_host (
        .clk        (clk),
        .host_sel_n (host_sel_n),
        .host_rd_n  (host_rd_n),
        .host_wr_n  (host_wr_n),
        .host_addr  (host_addr),
        .host_wdata (host_wdata),
        .rd_valid   (rd_valid)
    );

    ehc_regs u_dut (
        .clk             (clk),
        .rst             (rst),
        .host_sel_n      (host_sel_n),
        .host_rd_n       (host_rd_n),
        .host_wr_n       (host_wr_n),
        .host_addr       (host_addr),
        .host_wdata      (host_wdata),
        .host_rdata      (host_rdata),
        .phy_irq_req     (ev[5]),
        .rx_pkt_stored   (ev[4]),
        .tx_pkt_done     (ev[3]),
        .wdt_expired     (ev[1]),
        .rxbuf_full      (ev[0]),
        .wake_req        (wake_req),
        .tx_active_desc  (tx_active_desc),
        .tx_data_waiting (tx_data_waiting),
        .ctrl            (ctrl),
        .txcmd           (txcmd),
        .phy             (phy),
        .desc_in_use     (desc_in_use),
        .irq_out         (irq_out),
        .wake_out        (wake_out)
    );

    function automatic logic [36:0] pins_exp();
        logic act;
        act = |(stat_m & mask_m);
        return {act ~^ cmd_m[6], wake_req ~^ cmd_m[0], occ_m, cmd_m[15:14], cmd_m[9:8],
                cmd_m[6], cmd_m[0], txcfg_m[6], txcfg_m[4], phy_m[12:8], phy_m[6:4],
                txcmd_m[15:13], txcmd_m[11:0]};
    endfunction

    function automatic logic [31:0] rd_exp(input logic [15:0] a);
        case (a)
            `EHC_OFF_CMD:   return {16'h0, cmd_m};
            `EHC_OFF_MASK:  return {16'h0, mask_m};
            `EHC_OFF_STAT:  return {16'h0, stat_m};
            `EHC_OFF_TXCFG: return {16'h0, txcfg_m | {14'h0, tx_active_desc}};
            `EHC_OFF_TXCMD: return {16'h0, txcmd_m};
            `EHC_OFF_TRANSMIT_BUFFER_STATE:  return {23'h0, tx_data_waiting, 2'h0, tx_active_desc, occ_m};
            `EHC_OFF_PHY:   return {16'h0, phy_m};
            default:        return 32'h0;
        endcase
    endfunction

    task automatic w(input logic [15:0] a, input logic [31:0] d);
        case (a)
            `EHC_OFF_CMD:   cmd_m = d[15:0] & 16'hc341;
            `EHC_OFF_MASK:  mask_m = d[15:0] & 16'h003b;
            `EHC_OFF_STAT:  stat_m = stat_m & ~d[15:0];
            `EHC_OFF_TXCFG: txcfg_m = d[15:0] & 16'h0050;
            `EHC_OFF_TXCMD: txcmd_m = d[15:0] & 16'hefff;
            `EHC_OFF_TRANSMIT_BUFFER_STATE:  occ_m = d[3:0];
            `EHC_OFF_PHY:   phy_m = d[15:0] & 16'h1f70;
            default: ;
        endcase
        u_host.access(a, d, 1'b0);
    endtask

    task automatic r(input logic [15:0] a);
        note_q.push_back('{$sformatf("reg_%h", a), {5'h0, rd_exp(a)}});
        u_host.access(a, 32'h0, 1'b1);
    endtask

    task automatic pins();
        note_q.push_back('{"pins", pins_exp()});
        @(negedge clk);
        probe = 1'b1;
        @(negedge clk);
        probe = 1'b0;
    endtask

    task automatic pulse(input logic [5:0] bits);
        @(negedge clk);
        ev = bits;
        stat_m = stat_m | {10'h0, bits & 6'h3b};
        if (bits[3]) begin
            occ_m[tx_active_desc] = 1'b0;
        end
        @(negedge clk);
        ev = 6'h0;
    endtask

    task automatic close_out();
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Values read at the edge are those settled after the previous edge
    always @(posedge clk) begin
        if (rd_valid || probe) begin
            if (rd_valid) begin
                obs = {5'h0, host_rdata};
            end else begin
                obs = {irq_out, wake_out, desc_in_use, ctrl, phy, txcmd};
            end
            n = note_q.pop_front();
            n_tests++;
            if (obs !== n.exp) begin
                $display("unexpected %s expected %h seen %h", n.name, n.exp, obs);
                fails++;
            end
        end
    end

    initial begin
        #(WATCH_NS);
        fails++;
        close_out();
    end

    initial begin
        void'($urandom(8));
        repeat (4) @(negedge clk);
        rst = 1'b0;
        foreach (regs_a[i]) r(regs_a[i]);
        pins();
        foreach (regs_a[i]) begin
            w(regs_a[i], $urandom);
            r(regs_a[i]);
            pins();
        end
        for (int m = 0; m < 8; m++) begin
            w(`EHC_OFF_PHY, ($urandom & 32'h1f0f) | (m << 4));
            pins();
        end
        foreach (evt_b[k]) begin
            @(negedge clk);
            wake_req = $urandom;
            tx_active_desc = $urandom;
            tx_data_waiting = $urandom;
            w(`EHC_OFF_CMD, ($urandom & 32'hc301) | ((k % 2) << 6));
            w(`EHC_OFF_TRANSMIT_BUFFER_STATE, 32'hf);
            w(`EHC_OFF_MASK, 32'h0);
            pulse(6'h1 << evt_b[k]);
            pins();
            r(`EHC_OFF_TRANSMIT_BUFFER_STATE);
            r(`EHC_OFF_TXCFG);
            r(`EHC_OFF_STAT);
            w(`EHC_OFF_MASK, 32'h1 << evt_b[k]);
            pins();
            w(`EHC_OFF_STAT, 32'h3b ^ (32'h1 << evt_b[k]));
            r(`EHC_OFF_STAT);
            w(`EHC_OFF_STAT, 32'h1 << evt_b[k]);
            pins();
        end
        w(`EHC_OFF_MASK, 32'h3b);
        pulse(6'h3f);
        r(`EHC_OFF_STAT);
        pkt_desc = $urandom;
        pkt_cnt = $urandom;
        u_host.load_packet(pkt_desc, pkt_cnt, occ_m);
        txcmd_m = {1'b0, pkt_desc, 1'b0, pkt_cnt};
        occ_m = occ_m | (4'h1 << pkt_desc);
        pins();
        w(`EHC_OFF_STAT, 32'h3b);
        pins();
        close_out();
    end
endmodule
